// [pkg/iqc_pkg.sv]
// Constants and types for the interrupt output stage and pin interrupt setup
// Function
// - Read-only master interrupt bit 19 shows any enabled source active.
// - Master bit ignores output enable and interval gating.
// - Interval field bits 7:0, reset zero, counts 10 microsecond steps.
// - After assert then clear, output stays low the interval, then re-asserts.
// - Interval counting starts when sources clear from asserted state.
// - Self-clearing bit 9 restarts the interval counter, even mid-interval.
// - Read-only bit 8 high during interval; gated interrupts held off.
// - Writing zero interval stops gating, clears counter, issues pending.
// - New non-zero interval applies to later interrupts.
// - Wake interrupt bypasses interval gating.
// - Bits 30:28 pick LED (one) or general purpose pin (zero).
// - Polarity bits 26:24 choose active pin level: one high.
// - Pin interrupt counts only when its enable bit is set.
// - Pin level must persist over 80 ns to be recognised.
// - Pin flags in status bits 6:4 latch until written one.
package iqc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IQC_OFS_STATUS = 8'hc8;
  localparam logic [7:0] IQC_OFS_INTCFG = 8'hcc;
  localparam logic [7:0] IQC_OFS_PINCFG = 8'hd0;

  localparam int IQC_BIT_MASTER = 19;
  localparam int IQC_BIT_OUT_EN = 18;
  localparam int IQC_BIT_RESTART = 9;
  localparam int IQC_BIT_DEAS_ACT = 8;
  localparam int IQC_LSB_INTERVAL = 0;
  localparam int IQC_LSB_LED_SEL = 28;
  localparam int IQC_LSB_POLARITY = 24;
  localparam int IQC_LSB_PIN_FLAG = 4;

  localparam logic [7:0] IQC_RST_INTERVAL = 8'h00;
  localparam logic [2:0] IQC_RST_LED_SEL = 3'h0;
  localparam logic [2:0] IQC_RST_POLARITY = 3'h0;
  localparam logic IQC_RST_OUT_EN = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int IQC_CLK_PERIOD_NS = 20;
  localparam int IQC_TICK_US = 10;
  localparam int IQC_TICK_CYC = (IQC_TICK_US * 1000) / IQC_CLK_PERIOD_NS;
  localparam int IQC_FILT_NS = 80;
  // Strictly longer than the qualification time
  localparam int IQC_FILT_CYC = IQC_FILT_NS / IQC_CLK_PERIOD_NS + 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } iqc_reg_req_t;

endpackage : iqc_pkg

// [hw/iqc_top.sv]
// Interrupt output stage with de-assertion interval and pin interrupt setup
`timescale 1ns/1ps
`default_nettype none
module iqc_top
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire iqc_pkg::iqc_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire logic [2:0] gpio_in,
  input wire logic [2:0] pin_interrupt_enable,
  input wire logic other_irq_active,
  input wire logic wake_irq_active,
  output logic host_bus_bridge_irq,
  output logic [2:0] led_function_select
);
  import iqc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic wr_intcfg, wr_pincfg, wr_status;
  logic out_en_q;
  logic [7:0] interval_q;
  logic [2:0] led_sel_q;
  logic [2:0] polarity_q;
  logic restart;
  logic [2:0] flag_clr;

  assign wr_intcfg = reg_req.wr && (reg_req.addr == IQC_OFS_INTCFG);
  assign wr_pincfg = reg_req.wr && (reg_req.addr == IQC_OFS_PINCFG);
  assign wr_status = reg_req.wr && (reg_req.addr == IQC_OFS_STATUS);
  // Bit is never stored, so it reads back as zero
  assign restart = wr_intcfg && reg_req.wdata[IQC_BIT_RESTART];
  assign flag_clr = wr_status ?
    reg_req.wdata[IQC_LSB_PIN_FLAG +: 3] : 3'h0;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_en_q <= IQC_RST_OUT_EN;
      interval_q <= IQC_RST_INTERVAL;
    end
    else if (wr_intcfg)
    begin
      out_en_q <= reg_req.wdata[IQC_BIT_OUT_EN];
      interval_q <= reg_req.wdata[IQC_LSB_INTERVAL +: 8];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      led_sel_q <= IQC_RST_LED_SEL;
      polarity_q <= IQC_RST_POLARITY;
    end
    else if (wr_pincfg)
    begin
      led_sel_q <= reg_req.wdata[IQC_LSB_LED_SEL +: 3];
      polarity_q <= reg_req.wdata[IQC_LSB_POLARITY +: 3];
    end
  end

  assign led_function_select = led_sel_q;

  // ----------------------------------------------------------------
  // Pin interrupt qualification
  // ----------------------------------------------------------------
  logic [2:0] pin_flag_q;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pin
      logic meta_q, sync_q;
      logic [2:0] stable_q;
      logic hit;
      logic flag_q;

      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= gpio_in[gi];
          sync_q <= meta_q;
        end
      end

      // Pin must sit at its active level for the whole window
      assign hit = (sync_q == polarity_q[gi]) && !led_sel_q[gi];

      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          stable_q <= 3'h0;
        else if (!hit)
          stable_q <= 3'h0;
        else if (stable_q != 3'(IQC_FILT_CYC))
          stable_q <= stable_q + 3'h1;
      end

      // Set wins over a clear in the same cycle
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          flag_q <= 1'b0;
        else if (stable_q == 3'(IQC_FILT_CYC))
          flag_q <= 1'b1;
        else if (flag_clr[gi])
          flag_q <= 1'b0;
      end
      assign pin_flag_q[gi] = flag_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Source combination
  // ----------------------------------------------------------------
  logic gated_src, master;

  assign gated_src = |(pin_flag_q & pin_interrupt_enable)
    || other_irq_active;
  assign master = gated_src || wake_irq_active;

  // ----------------------------------------------------------------
  // De-assertion interval
  // ----------------------------------------------------------------
  logic [8:0] presc_q;
  logic tick;
  logic [7:0] deas_cnt_q;
  logic deas_act;
  logic delivered_q;
  logic src_cleared;

  assign deas_act = (deas_cnt_q != 8'h00);
  assign tick = (presc_q == 9'(IQC_TICK_CYC - 1));
  assign src_cleared = delivered_q && !gated_src;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      delivered_q <= 1'b0;
    else
      delivered_q <= gated_src && !deas_act && out_en_q;
  end

  // Prescaler restarts with each interval so the first step is whole
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      presc_q <= 9'h000;
    else if (src_cleared || restart || tick)
      presc_q <= 9'h000;
    else
      presc_q <= presc_q + 9'h001;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      deas_cnt_q <= 8'h00;
    else if (wr_intcfg && (reg_req.wdata[IQC_LSB_INTERVAL +: 8] == 8'h00))
      deas_cnt_q <= 8'h00;
    else if (restart)
      deas_cnt_q <= interval_q;
    else if (src_cleared)
      deas_cnt_q <= interval_q;
    else if (tick && deas_act)
      deas_cnt_q <= deas_cnt_q - 8'h01;
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  logic irq_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= out_en_q &&
        (wake_irq_active ||
         (gated_src && !deas_act));
  end
  assign host_bus_bridge_irq = irq_q;

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (reg_req.addr)
      IQC_OFS_STATUS:
        rd_mux[IQC_LSB_PIN_FLAG +: 3] = pin_flag_q;
      IQC_OFS_INTCFG:
      begin
        rd_mux[IQC_BIT_MASTER] = master;
        rd_mux[IQC_BIT_OUT_EN] = out_en_q;
        rd_mux[IQC_BIT_DEAS_ACT] = deas_act;
        rd_mux[IQC_LSB_INTERVAL +: 8] = interval_q;
      end
      IQC_OFS_PINCFG:
      begin
        rd_mux[IQC_LSB_LED_SEL +: 3] = led_sel_q;
        rd_mux[IQC_LSB_POLARITY +: 3] = polarity_q;
      end
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (reg_req.rd)
      rdata_q <= rd_mux;
  end
  assign reg_rdata = rdata_q;

endmodule // iqc_top
`default_nettype wire

// [verif/iqc_host_mdl.sv]
// Host side model counting interrupt deliveries
`timescale 1ns/1ps
`default_nettype none
module iqc_host_mdl
(
  input wire logic core_clk,
  input wire logic irq,
  output var logic [7:0] n_irq
);
  logic irq_q = 1'b0;
  initial n_irq = 8'h00;
  always @(posedge core_clk)
  begin
    irq_q <= irq;
    if (irq && !irq_q)
      n_irq <= n_irq + 8'h01;
  end
endmodule // iqc_host_mdl
`default_nettype wire

// [verif/iqc_chk.sv]
// Assertion checker for the interrupt output stage
`timescale 1ns/1ps
`default_nettype none
module iqc_chk
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire iqc_pkg::iqc_reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic other_irq_active,
  input wire logic wake_irq_active,
  input wire logic [2:0] pin_interrupt_enable,
  input wire logic host_bus_bridge_irq,
  input wire logic [2:0] led_function_select
);
  import iqc_pkg::*;
  logic [1:0] rcnt_q;
  logic en_q;
  logic [7:0] iv_q;
  logic rdy;
  logic rcc;
  logic irq;
  assign rdy = nrst && rcnt_q == 2'h3;
  assign rcc = reg_req.rd && reg_req.addr == IQC_OFS_INTCFG;
  assign irq = host_bus_bridge_irq;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      rcnt_q <= 2'h0;
    else if (rcnt_q != 2'h3)
      rcnt_q <= rcnt_q + 2'h1;
  // Shadow of output enable and interval
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      en_q <= 1'b0;
      iv_q <= 8'h00;
    end
    else if (reg_req.wr && reg_req.addr == IQC_OFS_INTCFG)
    begin
      en_q <= reg_req.wdata[IQC_BIT_OUT_EN];
      iv_q <= reg_req.wdata[7:0];
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rdy);
  a_en_gate: assert property (!$past(en_q) |-> !irq)
    else $error("irq while output disabled");
  a_wake_pass: assert property (en_q && wake_irq_active |=> irq)
    else $error("wake not delivered");
  a_irq_cause: assert property (irq && $past(pin_interrupt_enable) == 3'h0
    |-> $past(other_irq_active || wake_irq_active))
    else $error("irq without source");
  a_zero_iv: assert property (en_q && iv_q == 8'h00 && other_irq_active |=> irq)
    else $error("zero interval still gates");
  a_deas_hold: assert property ($fell(irq) && iv_q != 8'h00 &&
    $past(other_irq_active, 2) && !$past(wake_irq_active, 2)
    |-> (!irq || $past(wake_irq_active))[*8])
    else $error("interval not held");
  a_led_sel: assert property (reg_req.wr && reg_req.addr == IQC_OFS_PINCFG
    |=> led_function_select == $past(reg_req.wdata[30:28]))
    else $error("led select wrong");
  a_master: assert property (rcc && other_irq_active && $past(other_irq_active)
    |=> reg_rdata[IQC_BIT_MASTER])
    else $error("master bit low");
  a_cfg_rsvd: assert property (rcc |=> reg_rdata[31:20] == 12'h000
    && reg_rdata[17:9] == 9'h000)
    else $error("config reserved bits set");
endmodule // iqc_chk
bind iqc_top iqc_chk chk_u (.core_clk(core_clk), .nrst(nrst),
  .reg_req(reg_req), .reg_rdata(reg_rdata),
  .other_irq_active(other_irq_active), .wake_irq_active(wake_irq_active),
  .pin_interrupt_enable(pin_interrupt_enable),
  .host_bus_bridge_irq(host_bus_bridge_irq),
  .led_function_select(led_function_select));
`default_nettype wire

// [verif/testbench.sv]
// Self-checking testbench for the interrupt output stage
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import iqc_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  iqc_reg_req_t reg_req = '0;
  logic [31:0] reg_rdata, d;
  logic [2:0] gpio_in = 3'h0;
  logic [2:0] pin_interrupt_enable = 3'h0;
  logic other_irq_active = 1'b0;
  logic wake_irq_active = 1'b0;
  logic host_bus_bridge_irq;
  logic [2:0] led_function_select, pol, led;
  logic [7:0] n_irq;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int len;
  always #10 core_clk = ~core_clk;
  iqc_top dut_u (.core_clk(core_clk), .nrst(nrst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .gpio_in(gpio_in),
    .pin_interrupt_enable(pin_interrupt_enable),
    .other_irq_active(other_irq_active), .wake_irq_active(wake_irq_active),
    .host_bus_bridge_irq(host_bus_bridge_irq),
    .led_function_select(led_function_select));
  iqc_host_mdl host_u (.core_clk(core_clk), .irq(host_bus_bridge_irq),
    .n_irq(n_irq));
  task automatic test_done();
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge core_clk);
    reg_req = '0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge core_clk);
    reg_req = '0;
    d = reg_rdata;
    @(negedge core_clk);
  endtask
  task automatic cw(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Pins flag only for pulses over four cycles and outside LED mode
  function automatic logic [31:0] exp_flag(input int l, input logic [2:0] ld);
    return {25'h0, (l > 4) ? ~ld : 3'h0, 4'h0};
  endfunction
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    void'($urandom(20));
    cw(6);
    nrst = 1'b1;
    cw(3);
    rd(IQC_OFS_INTCFG);
    chk(d, 32'h0);
    rd(IQC_OFS_PINCFG);
    chk(d, 32'h0);
    rd(8'h40);
    chk(d, 32'h0);
    wr(IQC_OFS_INTCFG, 32'h0004_0001);
    other_irq_active = 1'b1;
    cw(2);
    chk(host_bus_bridge_irq, 1'b1);
    other_irq_active = 1'b0;
    cw(3);
    rd(IQC_OFS_INTCFG);
    chk(d[8], 1'b1);
    other_irq_active = 1'b1;
    cw(20);
    chk(host_bus_bridge_irq, 1'b0);
    wake_irq_active = 1'b1;
    cw(2);
    chk(host_bus_bridge_irq, 1'b1);
    wake_irq_active = 1'b0;
    cw(IQC_TICK_CYC - 40);
    chk(host_bus_bridge_irq, 1'b0);
    cw(40);
    chk(host_bus_bridge_irq, 1'b1);
    other_irq_active = 1'b0;
    cw(3);
    wr(IQC_OFS_INTCFG, 32'h0004_0002);
    wr(IQC_OFS_INTCFG, 32'h0004_0202);
    other_irq_active = 1'b1;
    cw(600);
    chk(host_bus_bridge_irq, 1'b0);
    rd(IQC_OFS_INTCFG);
    chk(d, 32'h000c_0102);
    wr(IQC_OFS_INTCFG, 32'h0004_0000);
    chk(host_bus_bridge_irq, 1'b1);
    wr(IQC_OFS_INTCFG, 32'h0);
    chk(host_bus_bridge_irq, 1'b0);
    rd(IQC_OFS_INTCFG);
    chk(d, 32'h0008_0000);
    chk(n_irq, 8'h04);
    other_irq_active = 1'b0;
    pin_interrupt_enable = 3'h7;
    for (int i = 0; i < 6; i++)
    begin
      pol = 3'($urandom);
      led = (i < 2) ? 3'h0 : 3'($urandom);
      len = (i < 2) ? 4 + i : 1 + int'($urandom % 8);
      wr(IQC_OFS_PINCFG, {1'b0, led, 1'b0, pol, 24'h0});
      chk(led_function_select, led);
      gpio_in = ~pol;
      cw(10);
      wr(IQC_OFS_STATUS, 32'h70);
      gpio_in = pol;
      cw(len);
      gpio_in = ~pol;
      cw(10);
      rd(IQC_OFS_STATUS);
      chk(d, exp_flag(len, led));
      wr(IQC_OFS_STATUS, 32'h0);
      rd(IQC_OFS_STATUS);
      chk(d, exp_flag(len, led));
      wr(IQC_OFS_STATUS, 32'h70);
      rd(IQC_OFS_STATUS);
      chk(d, 32'h0);
    end
    // Latched pin flags reach the output only through their enables
    pin_interrupt_enable = 3'h0;
    wr(IQC_OFS_PINCFG, 32'h0700_0000);
    gpio_in = 3'h7;
    cw(10);
    rd(IQC_OFS_INTCFG);
    chk(d, 32'h0);
    pin_interrupt_enable = 3'h2;
    cw(1);
    rd(IQC_OFS_INTCFG);
    chk(d, 32'h0008_0000);
    wr(IQC_OFS_INTCFG, 32'h0004_0000);
    cw(1);
    chk(host_bus_bridge_irq, 1'b1);
    test_done();
  end
endmodule // testbench
`default_nettype wire
